// [core/usi_cfg.svh]
// Constants for the two-wire shift interface: offsets, fields, resets, timing.
// Assumes a 125 MHz system clock; included by its bare name.
`ifndef USI_CFG_SVH
`define USI_CFG_SVH

// Register offsets on the plain register port
`define USI_ADDR_W      4
`define USI_ADDR_DATA   4'h0
`define USI_ADDR_STAT   4'h1
`define USI_ADDR_CTRL   4'h2
`define USI_ADDR_PORT   4'h3

// Status fields
`define USI_ST_START    7
`define USI_ST_WRAP     6
`define USI_ST_STOP     5
`define USI_ST_COLL     4
`define USI_ST_CNT_HI   3
`define USI_ST_CNT_LO   0

// Control fields; bits 1 and 0 are strobes and read as zero
`define USI_CT_START_IE 7
`define USI_CT_WRAP_IE  6
`define USI_CT_WM_HI    5
`define USI_CT_WM_LO    4
`define USI_CT_CS_HI    3
`define USI_CT_CS_LO    2
`define USI_CT_SOFT     1
`define USI_CT_TOGGLE   0

// Port fields: line levels and drive enables
`define USI_PT_SDA      0
`define USI_PT_SCL      1
`define USI_PT_SDA_DIR  2
`define USI_PT_SCL_DIR  3

// Reset values and counter constants
`define USI_RST_BYTE    8'h00
`define USI_RST_CNT     4'h0
`define USI_RST_PORT    4'h0
`define USI_CNT_MAX     4'hF
`define USI_CNT_ONE     4'h1
`define USI_BYTE_ZERO   8'h00

// Data line delay in front of the start detector
`define USI_CLK_NS      8
`define USI_SDA_DLY_NS  50
`define USI_SDA_DLY_MAX 40
`define USI_SDA_DLY_CYC ((`USI_SDA_DLY_NS + `USI_CLK_NS - 1) / `USI_CLK_NS)

`endif

// [core/usi_pkg.sv]
// Types for the two-wire shift interface.
// Assumes usi_cfg.svh is on the include path.
`include "usi_cfg.svh"

package usi_pkg;

	// Wire mode, in the order of its two-bit code
	typedef enum logic [1:0] {
		USI_WM_OFF,
		USI_WM_THREE,
		USI_WM_TWO,
		USI_WM_TWO_HOLD
	} usi_wire_mode_t;

	// Shift clock source, in the order of its two-bit code
	typedef enum logic [1:0] {
		USI_CS_SOFT,
		USI_CS_TIMER,
		USI_CS_EXT_POS,
		USI_CS_EXT_NEG
	} usi_clk_sel_t;

	// Synchroniser state
	typedef struct packed {
		logic meta;
		logic lvl;
		logic prev;
	} usi_sync_t;

	// Whole state of the interface apart from the pin synchronisers
	typedef struct packed {
		logic [7:0]                  sr;
		logic [3:0]                  cnt;
		logic                        start_f;
		logic                        wrap_f;
		logic                        stop_f;
		logic                        start_hold;
		logic                        latch;
		logic                        start_ie;
		logic                        wrap_ie;
		usi_wire_mode_t              wm;
		usi_clk_sel_t                cs;
		logic                        soft_count;
		logic [3:0]                  port;
		logic [`USI_SDA_DLY_MAX:0]   sda_dly;
		logic [7:0]                  rdata;
	} usi_state_t;

endpackage

// [core/usi_pin_sync.sv]
// Two-flop synchroniser with edge pulses for one pin input.
// Assumes the pin is asynchronous to clk; reset_n is synchronous.
`timescale 1ns/100ps
`default_nettype none

module usi_pin_sync (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic pin_async,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	import usi_pkg::*;

	usi_sync_t q;
	usi_sync_t d;

	// First stage feeds only the second stage
	always_comb begin
		d      = q;
		d.meta = pin_async;
		d.lvl  = q.meta;
		d.prev = q.lvl;
	end

	// Lines idle high, so reset to high to avoid a false edge
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= '{meta: 1'b1, lvl: 1'b1, prev: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign level = q.lvl;
	assign rise  = q.lvl & ~q.prev;
	assign fall  = ~q.lvl & q.prev;

endmodule // usi_pin_sync

`default_nettype wire

// [core/usi_two_wire.sv]
// Two-wire shift interface: shift register, edge counter, status flags,
// start and stop detection, clock stretching and open-drain line control.
// Assumes a 125 MHz clk, a synchronous active-low reset and bus lines
// that come in asynchronously; a timer match pulse comes from clk logic.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "usi_cfg.svh"

module usi_two_wire #(
	parameter int DLY_CYC = `USI_SDA_DLY_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic [`USI_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	input  wire logic                   timer_match,
	input  wire logic                   sda_in,
	output logic                        sda_out,
	output logic                        sda_oe,
	input  wire logic                   scl_in,
	output logic                        scl_out,
	output logic                        scl_oe,
	output logic                        do_out,
	output logic                        do_oe,
	output logic                        start_irq,
	output logic                        wrap_irq
);
	import usi_pkg::*;

	// The delay tap must exist in the delay line
	if (DLY_CYC < 1 || DLY_CYC > `USI_SDA_DLY_MAX) begin : g_chk
		$error("DLY_CYC out of range");
	end

	usi_state_t q;
	usi_state_t d;

	logic sda_lvl;
	logic sda_rise;
	logic sda_fall;
	logic scl_lvl;
	logic scl_rise;
	logic scl_fall;

	// Both lines pass two flops; a quarter-rate bus leaves
	// every edge visible at least once
	usi_pin_sync u_sda_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.pin_async(sda_in),
		.level    (sda_lvl),
		.rise     (sda_rise),
		.fall     (sda_fall)
	);

	usi_pin_sync u_scl_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.pin_async(scl_in),
		.level    (scl_lvl),
		.rise     (scl_rise),
		.fall     (scl_fall)
	);

	// Register port decode
	logic wr_data;
	logic wr_stat;
	logic wr_ctrl;
	logic wr_port;
	logic soft_wr;
	logic toggle_wr;

	assign wr_data   = reg_wr && (reg_addr == `USI_ADDR_DATA);
	assign wr_stat   = reg_wr && (reg_addr == `USI_ADDR_STAT);
	assign wr_ctrl   = reg_wr && (reg_addr == `USI_ADDR_CTRL);
	assign wr_port   = reg_wr && (reg_addr == `USI_ADDR_PORT);
	assign soft_wr   = wr_ctrl && reg_wdata[`USI_CT_SOFT];
	assign toggle_wr = wr_ctrl && reg_wdata[`USI_CT_TOGGLE];

	// Mode decode
	logic two_wire;
	logic three_wire;
	logic ext_clk;

	assign two_wire   = (q.wm == USI_WM_TWO) || (q.wm == USI_WM_TWO_HOLD);
	assign three_wire = (q.wm == USI_WM_THREE);
	assign ext_clk    = (q.cs == USI_CS_EXT_POS) || (q.cs == USI_CS_EXT_NEG);

	// Shift and count events from the chosen source
	logic shift_ev;
	logic cnt_ev;

	always_comb begin
		shift_ev = 1'b0;
		cnt_ev   = 1'b0;
		unique case (q.cs)
			USI_CS_SOFT: begin
				shift_ev = soft_wr;
				cnt_ev   = soft_wr;
			end
			USI_CS_TIMER: begin
				shift_ev = timer_match;
				cnt_ev   = timer_match;
			end
			USI_CS_EXT_POS: begin
				shift_ev = scl_rise;
				cnt_ev   = q.soft_count ? toggle_wr : (scl_rise | scl_fall);
			end
			USI_CS_EXT_NEG: begin
				shift_ev = scl_fall;
				cnt_ev   = q.soft_count ? toggle_wr : (scl_rise | scl_fall);
			end
		endcase
	end

	// Counter step; a software load of the counter takes priority
	logic cnt_inc;
	logic wrap_ev;

	assign cnt_inc = cnt_ev && !wr_stat;
	assign wrap_ev = cnt_inc && (q.cnt == `USI_CNT_MAX);

	// Start seen on the delayed data line so the clock line is settled
	logic dly_now;
	logic dly_old;
	logic start_cond;
	logic stop_cond;

	assign dly_now = q.sda_dly[DLY_CYC - 1];
	assign dly_old = q.sda_dly[DLY_CYC];
	assign start_cond = two_wire && dly_old && !dly_now && scl_lvl;
	assign stop_cond  = two_wire && sda_rise && scl_lvl;

	// Flag set and clear sources
	logic start_set;
	logic start_clr;
	logic wrap_clr;
	logic stop_clr;

	assign start_set = two_wire ? start_cond : cnt_inc;
	assign start_clr = wr_stat && reg_wdata[`USI_ST_START];
	assign wrap_clr  = wr_stat && reg_wdata[`USI_ST_WRAP];
	assign stop_clr  = wr_stat && reg_wdata[`USI_ST_STOP];

	// Latch opens in the half cycle opposite the sampling edge
	logic latch_open;

	always_comb begin
		latch_open = 1'b1;
		if (q.cs == USI_CS_EXT_POS) begin
			latch_open = !scl_lvl;
		end else if (q.cs == USI_CS_EXT_NEG) begin
			latch_open = scl_lvl;
		end
	end

	logic collision;

	assign collision = q.sr[7] ^ sda_lvl;

	// Next state
	always_comb begin
		d = q;

		// Delay line for the start detector
		d.sda_dly = {q.sda_dly[`USI_SDA_DLY_MAX-1:0], sda_lvl};

		// Unbuffered shifter; a write in the shift cycle wins
		if (wr_data) begin
			d.sr = reg_wdata;
		end else if (shift_ev) begin
			d.sr = {q.sr[6:0], sda_lvl};
		end

		// Edge counter, loadable through the status low nibble
		if (wr_stat) begin
			d.cnt = reg_wdata[`USI_ST_CNT_HI:`USI_ST_CNT_LO];
		end else if (cnt_inc) begin
			d.cnt = q.cnt + `USI_CNT_ONE;
		end

		// Sticky flags: a set in the clearing cycle wins
		d.start_f = (q.start_f && !start_clr) || start_set;
		d.wrap_f  = (q.wrap_f && !wrap_clr) || wrap_ev;
		d.stop_f  = (q.stop_f && !stop_clr) || stop_cond;

		// Start hold engages once the master pulls the clock low
		if (!d.start_f || !two_wire) begin
			d.start_hold = 1'b0;
		end else if (q.start_f && !scl_lvl) begin
			d.start_hold = 1'b1;
		end

		// Output latch follows the top bit while open
		if (latch_open) begin
			d.latch = d.sr[7];
		end

		// Control register
		if (wr_ctrl) begin
			d.start_ie   = reg_wdata[`USI_CT_START_IE];
			d.wrap_ie    = reg_wdata[`USI_CT_WRAP_IE];
			d.wm         = usi_wire_mode_t'(reg_wdata[`USI_CT_WM_HI:`USI_CT_WM_LO]);
			d.cs         = usi_clk_sel_t'(reg_wdata[`USI_CT_CS_HI:`USI_CT_CS_LO]);
			d.soft_count = reg_wdata[`USI_CT_SOFT] && reg_wdata[`USI_CT_CS_HI];
		end

		// Port bits; the toggle strobe flips the clock level
		if (wr_port) begin
			d.port = reg_wdata[3:0];
		end
		if (toggle_wr) begin
			d.port[`USI_PT_SCL] = !d.port[`USI_PT_SCL];
		end

		// Read data stands for one cycle after the strobe
		d.rdata = `USI_BYTE_ZERO;
		if (reg_rd) begin
			unique case (reg_addr)
				`USI_ADDR_DATA: d.rdata = q.sr;
				`USI_ADDR_STAT: d.rdata = {q.start_f, q.wrap_f, q.stop_f, collision, q.cnt};
				`USI_ADDR_CTRL: d.rdata = {q.start_ie, q.wrap_ie, q.wm, q.cs, 2'b00};
				`USI_ADDR_PORT: d.rdata = {4'h0, q.port};
				default:        d.rdata = `USI_BYTE_ZERO;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= '{
				sr:         `USI_RST_BYTE,
				cnt:        `USI_RST_CNT,
				start_f:    1'b0,
				wrap_f:     1'b0,
				stop_f:     1'b0,
				start_hold: 1'b0,
				latch:      1'b0,
				start_ie:   1'b0,
				wrap_ie:    1'b0,
				wm:         USI_WM_OFF,
				cs:         USI_CS_SOFT,
				soft_count: 1'b0,
				port:       `USI_RST_PORT,
				sda_dly:    '1,
				rdata:      `USI_RST_BYTE
			};
		end else begin
			q <= d;
		end
	end

	// Clock line hold sources
	logic hold_low;

	assign hold_low = q.start_hold
		|| ((q.wm == USI_WM_TWO_HOLD) && q.wrap_f);

	// Data line: open drain in two-wire, pulled low by shifter or port
	assign sda_out = 1'b0;
	assign sda_oe  = two_wire && q.port[`USI_PT_SDA_DIR]
		&& (!q.latch || !q.port[`USI_PT_SDA]);

	// Clock line: push-pull in three-wire, open drain in two-wire
	assign scl_out = three_wire && q.port[`USI_PT_SCL];
	assign scl_oe  = three_wire ? q.port[`USI_PT_SCL_DIR]
		: (two_wire && q.port[`USI_PT_SCL_DIR]
		&& (!q.port[`USI_PT_SCL] || hold_low));

	// Separate data output pin for three-wire mode
	assign do_out = q.latch;
	assign do_oe  = three_wire && q.port[`USI_PT_SDA_DIR];

	// Interrupt requests are levels; the flags stay until cleared
	assign start_irq = q.start_f && q.start_ie;
	assign wrap_irq  = q.wrap_f && q.wrap_ie;

	assign reg_rdata = q.rdata;

endmodule // usi_two_wire

`default_nettype wire

// [sim/usi_two_wire_props.sv]
// Port checker for the two-wire shift interface.
// Assumes it is bound into usi_two_wire and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "usi_cfg.svh"

module usi_two_wire_props #(
	parameter int DLY_CYC = `USI_SDA_DLY_CYC
) (
	input wire logic                   clk,
	input wire logic                   reset_n,
	input wire logic [`USI_ADDR_W-1:0] reg_addr,
	input wire logic [7:0]             reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   scl_in,
	input wire logic                   sda_out,
	input wire logic                   scl_out,
	input wire logic                   sda_oe,
	input wire logic                   scl_oe,
	input wire logic                   do_oe,
	input wire logic                   start_irq,
	input wire logic                   wrap_irq
);
	logic [7:0] ct_q;
	logic [3:0] pt_q;

	// Shadow of control and port writes; the toggle strobe is not mirrored
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ct_q <= 8'h00;
			pt_q <= 4'h0;
		end else if (reg_wr && reg_addr == `USI_ADDR_CTRL) begin
			ct_q <= reg_wdata;
		end else if (reg_wr && reg_addr == `USI_ADDR_PORT) begin
			pt_q <= reg_wdata[3:0];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Status write with one flag bit set
	sequence s_clr(b);
		reg_wr && reg_addr == `USI_ADDR_STAT && reg_wdata[b];
	endsequence
	// Start flag pending while the clock line sits low in two-wire mode
	sequence s_held;
		(start_irq && ct_q[5] && pt_q[3] && !scl_in)[*6];
	endsequence

	outs_off_a: assert property (ct_q[5:4] == 2'h0 |-> !sda_oe && !scl_oe && !do_oe)
		else $error("outputs driven with wire mode off");
	open_drain_a: assert property (ct_q[5] |-> !sda_out && !scl_out)
		else $error("line driven high in two-wire mode");
	start_gate_a: assert property (!ct_q[7] |-> !start_irq)
		else $error("start irq without enable");
	wrap_gate_a: assert property (!ct_q[6] |-> !wrap_irq)
		else $error("wrap irq without enable");
	start_clr_a: assert property (s_clr(7) ##0 ct_q[5] |=> !start_irq)
		else $error("start flag survived clear");
	wrap_clr_a: assert property (s_clr(6) |=> !wrap_irq)
		else $error("wrap flag survived clear");
	start_hold_a: assert property (s_held |-> scl_oe)
		else $error("clock not held after start");
	wrap_hold_a: assert property (wrap_irq && $past(wrap_irq) && ct_q[5:4] == 2'h3 && pt_q[3] |-> scl_oe)
		else $error("clock not held after wrap");
	hold_free_a: assert property ($fell(start_irq) && ct_q[7:5] == 3'h7 && !wrap_irq && pt_q[1]
		|-> ##[0:2] !scl_oe)
		else $error("clock hold not released");
endmodule // usi_two_wire_props

bind usi_two_wire usi_two_wire_props #(.DLY_CYC(DLY_CYC)) usi_two_wire_props_inst (
	.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.scl_in(scl_in), .sda_out(sda_out), .scl_out(scl_out), .sda_oe(sda_oe), .scl_oe(scl_oe),
	.do_oe(do_oe), .start_irq(start_irq), .wrap_irq(wrap_irq));
`default_nettype wire

// [sim/usi_bus_master.sv]
// Bus master model for the two-wire line pair: start, bits, stop.
// Assumes the bench resolves pulled-up lines; this model only pulls low.
`timescale 1ns/100ps
`default_nettype none

module usi_bus_master #(
	parameter realtime HALF = 62.5
) (
	input  wire logic scl,
	input  wire logic sda,
	output var logic  scl_lo,
	output var logic  sda_lo
);
	// Lines released at start
	initial begin
		scl_lo = 1'b0;
		sda_lo = 1'b0;
	end

	// A slave may stretch the clock, so wait until it really rises
	task automatic hi_wait();
		for (int k = 0; k < 500 && scl !== 1'b1; k++) #10;
	endtask

	// Data falls with clock high; long setup so the delayed detector sees it
	task automatic start();
		sda_lo = 1'b1;
		#(2 * HALF);
		scl_lo = 1'b1;
	endtask

	// MSB first; data changes as the clock falls and gets a long low phase,
	// so the delayed start detector never sees a data fall with the clock high
	task automatic bits(input logic [7:0] b, input int n, output logic [7:0] s);
		s = 8'h00;
		for (int i = 0; i < n; i++) begin
			sda_lo = !b[7-i];
			#(HALF + HALF / 2);
			scl_lo = 1'b0;
			hi_wait();
			#(HALF / 2);
			s = {s[6:0], sda};
			scl_lo = 1'b1;
		end
	endtask

	// Data falls early in the low phase, then rises while clock is high
	task automatic stop();
		sda_lo = 1'b1;
		#(HALF + HALF / 2);
		scl_lo = 1'b0;
		hi_wait();
		#HALF;
		sda_lo = 1'b0;
		#HALF;
	endtask
endmodule // usi_bus_master
`default_nettype wire

// [sim/tb_usi_two_wire.sv]
// Testbench for the two-wire shift interface with a bus master model.
// Assumes usi_cfg.svh on the include path and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
`include "usi_cfg.svh"

module tb_usi_two_wire;
	logic       clk, reset_n, reg_wr, reg_rd, timer_match;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic       sda_out, sda_oe, scl_out, scl_oe, do_out, do_oe, start_irq, wrap_irq;
	logic       m_scl_lo, m_sda_lo, scl_ln, sda_ln;
	int         fail_count, num_checks;

	// Pulled-up lines: anyone enabled and driving low pulls low
	assign scl_ln = !(m_scl_lo || (scl_oe && !scl_out));
	assign sda_ln = !(m_sda_lo || (sda_oe && !sda_out));

	usi_two_wire usi_two_wire_inst (
		.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_match(timer_match), .sda_in(sda_ln),
		.sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_ln), .scl_out(scl_out), .scl_oe(scl_oe),
		.do_out(do_out), .do_oe(do_oe), .start_irq(start_irq), .wrap_irq(wrap_irq));
	usi_bus_master usi_bus_master_inst (.scl(scl_ln), .sda(sda_ln), .scl_lo(m_scl_lo), .sda_lo(m_sda_lo));

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// One-cycle write; ends mid-cycle so flags have settled
	task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic tm = 1'b0);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		timer_match <= tm;
		@(posedge clk);
		reg_wr <= 1'b0;
		timer_match <= 1'b0;
		@(negedge clk);
	endtask

	// Read and compare; data stands only in the cycle after the strobe,
	// so it is looked at on the falling edge inside that cycle
	task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(n, e, reg_rdata);
	endtask

	// Reset values and an unmapped place; the idle data line differs from a clear top bit
	task automatic t_regs();
		wr(4'h9, 8'h5A);
		rc("unmapped", 4'h9, 8'h00);
		rc("data", `USI_ADDR_DATA, 8'h00);
		rc("status", `USI_ADDR_STAT, 8'h10);
		rc("control", `USI_ADDR_CTRL, 8'h00);
		rc("port", `USI_ADDR_PORT, 8'h00);
	endtask

	// Software strobe from a preset maximum count
	task automatic t_soft();
		wr(`USI_ADDR_DATA, 8'h81);
		wr(`USI_ADDR_STAT, 8'h0F);
		wr(`USI_ADDR_CTRL, 8'h02);
		rc("status", `USI_ADDR_STAT, 8'hD0);
		rc("data", `USI_ADDR_DATA, 8'h03);
		rc("strobes", `USI_ADDR_CTRL, 8'h00);
		wr(`USI_ADDR_CTRL, 8'h40);
		chk("wrap_irq", 8'h01, {7'h00, wrap_irq});
		wr(`USI_ADDR_STAT, 8'hE0);
		chk("wrap_irq", 8'h00, {7'h00, wrap_irq});
		rc("status", `USI_ADDR_STAT, 8'h10);
	endtask

	// Timer shift colliding with a data write, then a lone shift
	task automatic t_sync();
		wr(`USI_ADDR_CTRL, 8'h04);
		wr(`USI_ADDR_DATA, 8'hA5, 1'b1);
		rc("data", `USI_ADDR_DATA, 8'hA5);
		wr(4'h9, 8'h00, 1'b1);
		rc("data", `USI_ADDR_DATA, 8'h4B);
	endtask

	// A start condition with outputs off is not detected
	task automatic t_off();
		wr(`USI_ADDR_CTRL, 8'h00);
		wr(`USI_ADDR_STAT, 8'hE0);
		usi_bus_master_inst.start();
		repeat (20) @(posedge clk);
		rc("status", `USI_ADDR_STAT, 8'h00);
		usi_bus_master_inst.stop();
	endtask

	// Slave receive with start hold, wrap hold, acknowledge and stop; the top
	// bit is set while the latch is still open, so enabling the drivers pulls nothing
	task automatic t_slave();
		logic [7:0] s;
		wr(`USI_ADDR_DATA, 8'hFF);
		wr(`USI_ADDR_CTRL, 8'hF8);
		wr(`USI_ADDR_PORT, 8'h0F);
		wr(`USI_ADDR_STAT, 8'hE0);
		usi_bus_master_inst.start();
		repeat (8) @(negedge clk);
		chk("start_irq", 8'h01, {7'h00, start_irq});
		chk("start hold", 8'h01, {7'h00, scl_oe});
		wr(`USI_ADDR_STAT, 8'h80);
		chk("hold free", 8'h00, {7'h00, scl_oe});
		usi_bus_master_inst.bits(8'hA6, 8, s);
		repeat (8) @(negedge clk);
		chk("wrap hold", 8'h01, {7'h00, scl_oe});
		rc("address", `USI_ADDR_DATA, 8'hA6);
		rc("status", `USI_ADDR_STAT, 8'h50);
		wr(`USI_ADDR_DATA, 8'h00);
		wr(`USI_ADDR_STAT, 8'h4E);
		usi_bus_master_inst.bits(8'h80, 1, s);
		chk("ack", 8'h00, {7'h00, s[0]});
		repeat (8) @(negedge clk);
		chk("ack hold", 8'h01, {7'h00, scl_oe});
		wr(`USI_ADDR_DATA, 8'hFF);
		wr(`USI_ADDR_STAT, 8'h40);
		usi_bus_master_inst.stop();
		repeat (8) @(negedge clk);
		rc("status", `USI_ADDR_STAT, 8'h21);
	endtask

	// Three-wire outputs, falling-edge shift and latch, clocked by the toggle strobe
	task automatic t_three();
		wr(`USI_ADDR_CTRL, 8'h00);
		wr(`USI_ADDR_STAT, 8'hE0);
		wr(`USI_ADDR_DATA, 8'h80);
		wr(`USI_ADDR_CTRL, 8'h1C);
		wr(`USI_ADDR_PORT, 8'h0E);
		repeat (4) @(negedge clk);
		chk("do_oe", 8'h01, {7'h00, do_oe});
		chk("do_out", 8'h01, {7'h00, do_out});
		chk("three clock oe", 8'h01, {7'h00, scl_oe});
		chk("three clock out", 8'h01, {7'h00, scl_out});
		wr(`USI_ADDR_CTRL, 8'h1D);
		repeat (4) @(negedge clk);
		chk("do_out held", 8'h01, {7'h00, do_out});
		wr(`USI_ADDR_CTRL, 8'h1D);
		repeat (4) @(negedge clk);
		chk("do_out moved", 8'h00, {7'h00, do_out});
		rc("data", `USI_ADDR_DATA, 8'h01);
		rc("status", `USI_ADDR_STAT, 8'h92);
		rc("control", `USI_ADDR_CTRL, 8'h1C);
	endtask

	// Main sequence
	initial begin
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		timer_match = 1'b0;
		fail_count = 0;
		num_checks = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_soft();
		t_sync();
		t_off();
		t_slave();
		t_three();
		end_sim();
	end

	// Watchdog well beyond the expected run
	initial begin
		#300000;
		fail_count++;
		end_sim();
	end
endmodule // tb_usi_two_wire
`default_nettype wire
